// ### common/eac_defs.svh
// constants of the byte eeprom access controller: offsets, fields, resets,
// stall and arm counts, programming times.
// assumes a 32-bit classic wishbone slave with byte-addressed words.
`ifndef EAC_DEFS_SVH
`define EAC_DEFS_SVH

// ==========================================================================
// register byte offsets
`define EAC_ADR_CTRL 4'h0
`define EAC_ADR_ADDR 4'h4
`define EAC_ADR_DATA 4'h8

// ==========================================================================
// control register fields
`define EAC_CTRL_RD 0
`define EAC_CTRL_PB 1
`define EAC_CTRL_ARM 2
`define EAC_CTRL_IEN 3
`define EAC_CTRL_MODE_LO 4
`define EAC_CTRL_MODE_HI 5

// ==========================================================================
// reset values
`define EAC_MODE_RST 2'h0
`define EAC_ADDR_RST 8'h00
`define EAC_DATA_RST 8'h00

// ==========================================================================
// cycle counts on clk_sys
`define EAC_RD_STALL 3'h4
`define EAC_PR_STALL 3'h2
`define EAC_ARM_CYC 3'h4

// ==========================================================================
// programming times, microseconds, and oscillator rate in khz
`define EAC_T_ATOMIC_US 3400
`define EAC_T_SPLIT_US 1800
`define EAC_OSC_KHZ 8000

`endif

// ### common/eac_pkg.sv
// types of the byte eeprom access controller.
// assumes eac_defs.svh for the numeric constants; the enum encodings here are literal.
package eac_pkg;

  // ========================================================================
  // programming mode and bus states
  typedef enum logic [1:0] {
    EAC_MODE_ATOMIC = 2'h0,
    EAC_MODE_ERASE = 2'h1,
    EAC_MODE_WRITE = 2'h2,
    EAC_MODE_RSVD = 2'h3
  } eac_mode_t;

  typedef enum logic [1:0] {
    EAC_ST_IDLE = 2'h0,
    EAC_ST_WAIT = 2'h1,
    EAC_ST_ACK = 2'h3
  } eac_bus_st_t;

endpackage : eac_pkg

// ### common/eac_nvm_if.sv
// link between the register front end and the array with its op timer.
// assumes both ends on clk_sys.
`timescale 1ns/1ns
interface eac_nvm_if;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic op_start;
  eac_pkg::eac_mode_t op_mode;
  logic [7:0] op_addr;
  logic [7:0] op_data;
  logic op_busy;

  modport ctl (output rd_addr, op_start, op_mode, op_addr, op_data,
               input rd_data, op_busy);
  modport mem (input rd_addr, op_start, op_mode, op_addr, op_data,
               output rd_data, op_busy);
endinterface : eac_nvm_if

// ### verilog/eac_nvm.sv
// 256-byte array with the programming timer.
// assumes osc_tick is a one-cycle pulse per oscillator period on clk_sys.
`timescale 1ns/1ns
`include "eac_defs.svh"
module eac_nvm #(
  parameter int ATOMIC_TICKS = (`EAC_T_ATOMIC_US * `EAC_OSC_KHZ) / 1000,
  parameter int SPLIT_TICKS = (`EAC_T_SPLIT_US * `EAC_OSC_KHZ) / 1000,
  parameter int CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic osc_tick,
  eac_nvm_if.mem nvm
);
  import eac_pkg::*;

  if (ATOMIC_TICKS < 1 || SPLIT_TICKS < 1 ||
      ATOMIC_TICKS >= (1 << CNT_W) || SPLIT_TICKS >= (1 << CNT_W))
  begin : g_bad_ticks
    $error("eac_nvm: tick counts out of range");
  end

  logic [7:0] mem_q [256];
  logic busy_q;
  logic [CNT_W-1:0] cnt_q;
  eac_mode_t mode_q;
  logic [7:0] addr_q;
  logic [7:0] data_q;

  // ========================================================================
  // read path
  assign nvm.rd_data = mem_q[nvm.rd_addr];
  assign nvm.op_busy = busy_q;

  // ========================================================================
  // op timer, counted in oscillator ticks
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
      mode_q <= EAC_MODE_ATOMIC;
      addr_q <= 8'h00;
      data_q <= 8'h00;
    end else if (nvm.op_start && !busy_q) begin
      busy_q <= 1'b1;
      mode_q <= nvm.op_mode;
      addr_q <= nvm.op_addr;
      data_q <= nvm.op_data;
      if (nvm.op_mode == EAC_MODE_ATOMIC) begin
        cnt_q <= CNT_W'(ATOMIC_TICKS);
      end else begin
        cnt_q <= CNT_W'(SPLIT_TICKS);
      end
    end else if (busy_q && osc_tick) begin
      if (cnt_q == CNT_W'(1)) begin
        busy_q <= 1'b0;
      end
      cnt_q <= cnt_q - CNT_W'(1);
    end
  end

  // ========================================================================
  // array update at end of op
  always_ff @(posedge clk_sys) begin
    if (busy_q && osc_tick && cnt_q == CNT_W'(1)) begin
      case (mode_q)
        EAC_MODE_ATOMIC: mem_q[addr_q] <= data_q;
        EAC_MODE_ERASE: mem_q[addr_q] <= 8'hff;
        EAC_MODE_WRITE: mem_q[addr_q] <= mem_q[addr_q] & data_q;
        default: mem_q[addr_q] <= mem_q[addr_q];
      endcase
    end
  end

  done_clears_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    busy_q && osc_tick && cnt_q == CNT_W'(1) |=> !busy_q)
    else $error("op did not end at terminal count");

endmodule : eac_nvm

// ### verilog/eac_top.sv
// byte eeprom access controller: wishbone register front end.
// assumes a classic wishbone master on clk_sys and an osc_tick strobe.
//
// Local design decisions: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
`include "eac_defs.svh"
module eac_top #(
  parameter int ATOMIC_TICKS = (`EAC_T_ATOMIC_US * `EAC_OSC_KHZ) / 1000,
  parameter int SPLIT_TICKS = (`EAC_T_SPLIT_US * `EAC_OSC_KHZ) / 1000
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic osc_tick,
  input wire logic global_irq_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic nvm_ready_irq
);
  import eac_pkg::*;

  eac_nvm_if nvm ();

  eac_bus_st_t st_q;
  logic [2:0] stall_q;
  logic go_rd_q;
  logic go_pr_q;
  logic [31:0] dat_q;
  eac_mode_t mode_q;
  logic ien_q;
  logic arm_q;
  logic [2:0] arm_cnt_q;
  logic [7:0] addr_q;
  logic [7:0] data_q;
  logic take;
  logic fire;
  logic busy;
  logic ctrl_wr;
  logic go_rd_d;
  logic go_pr_d;
  logic [2:0] stall_d;
  logic [7:0] ctrl_rd;
  logic [31:0] rd_word;

  // ========================================================================
  // decode
  function automatic logic is_reg(input logic [3:0] adr,
                                  input logic [3:0] off);
    is_reg = (adr == off);
  endfunction : is_reg

  assign busy = nvm.op_busy;
  assign take = (st_q == EAC_ST_IDLE) && wb_cyc_i && wb_stb_i;
  assign fire = (st_q == EAC_ST_ACK);
  assign wb_ack_o = fire;
  assign ctrl_wr = wb_we_i && wb_sel_i[0] && is_reg(wb_adr_i, `EAC_ADR_CTRL);

  always_comb begin
    go_pr_d = ctrl_wr && wb_dat_i[`EAC_CTRL_PB] && arm_q && !busy &&
              (mode_q != EAC_MODE_RSVD);
    go_rd_d = ctrl_wr && wb_dat_i[`EAC_CTRL_RD] && !busy && !go_pr_d;
    if (go_rd_d) begin
      stall_d = `EAC_RD_STALL;
    end else if (go_pr_d) begin
      stall_d = `EAC_PR_STALL;
    end else begin
      stall_d = 3'h0;
    end
  end

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`EAC_CTRL_PB] = busy;
    ctrl_rd[`EAC_CTRL_ARM] = arm_q;
    ctrl_rd[`EAC_CTRL_IEN] = ien_q;
    ctrl_rd[`EAC_CTRL_MODE_HI:`EAC_CTRL_MODE_LO] = mode_q;
    if (is_reg(wb_adr_i, `EAC_ADR_CTRL)) begin
      rd_word = {24'h000000, ctrl_rd};
    end else if (is_reg(wb_adr_i, `EAC_ADR_ADDR)) begin
      rd_word = {24'h000000, addr_q};
    end else if (is_reg(wb_adr_i, `EAC_ADR_DATA)) begin
      rd_word = {24'h000000, data_q};
    end else begin
      rd_word = 32'h00000000;
    end
  end

  // ========================================================================
  // bus sequencer, stalls the cpu by holding back ack
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= EAC_ST_IDLE;
      stall_q <= 3'h0;
      go_rd_q <= 1'b0;
      go_pr_q <= 1'b0;
    end else begin
      case (st_q)
        EAC_ST_IDLE: begin
          if (take) begin
            go_rd_q <= go_rd_d;
            go_pr_q <= go_pr_d;
            stall_q <= stall_d;
            st_q <= (stall_d != 3'h0) ? EAC_ST_WAIT : EAC_ST_ACK;
          end
        end
        EAC_ST_WAIT: begin
          stall_q <= stall_q - 3'h1;
          if (stall_q == 3'h1) begin
            st_q <= EAC_ST_ACK;
          end
        end
        EAC_ST_ACK: begin
          go_rd_q <= 1'b0;
          go_pr_q <= 1'b0;
          st_q <= EAC_ST_IDLE;
        end
        default: st_q <= EAC_ST_IDLE;
      endcase
    end
  end

  // ========================================================================
  // read data register for the bus
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dat_q <= 32'h00000000;
    end else if (wb_cyc_i && wb_stb_i && !wb_we_i && st_q != EAC_ST_ACK) begin
      dat_q <= rd_word;
    end
  end
  assign wb_dat_o = dat_q;

  // ========================================================================
  // control register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= EAC_MODE_ATOMIC;
      ien_q <= 1'b0;
    end else if (fire && ctrl_wr) begin
      if (!busy) begin
        mode_q <= eac_mode_t'(
          wb_dat_i[`EAC_CTRL_MODE_HI:`EAC_CTRL_MODE_LO]);
      end
      ien_q <= wb_dat_i[`EAC_CTRL_IEN];
    end
  end

  // ========================================================================
  // master arm window
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      arm_q <= 1'b0;
      arm_cnt_q <= 3'h0;
    end else if (fire && ctrl_wr && wb_dat_i[`EAC_CTRL_ARM] && !arm_q) begin
      arm_q <= 1'b1;
      arm_cnt_q <= `EAC_ARM_CYC;
    end else if (arm_q) begin
      arm_cnt_q <= arm_cnt_q - 3'h1;
      if (arm_cnt_q == 3'h1) begin
        arm_q <= 1'b0;
      end
    end
  end

  // ========================================================================
  // address and data registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= `EAC_ADDR_RST;
    end else if (fire && wb_we_i && wb_sel_i[0] &&
                 is_reg(wb_adr_i, `EAC_ADR_ADDR)) begin
      addr_q <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      data_q <= `EAC_DATA_RST;
    end else if (fire && go_rd_q) begin
      data_q <= nvm.rd_data;
    end else if (fire && wb_we_i && wb_sel_i[0] &&
                 is_reg(wb_adr_i, `EAC_ADR_DATA)) begin
      data_q <= wb_dat_i[7:0];
    end
  end

  // ========================================================================
  // array link and ready irq
  assign nvm.rd_addr = addr_q;
  assign nvm.op_start = fire && go_pr_q;
  assign nvm.op_mode = mode_q;
  assign nvm.op_addr = addr_q;
  assign nvm.op_data = data_q;
  assign nvm_ready_irq = ien_q && global_irq_en && !busy;

  eac_nvm #(
    .ATOMIC_TICKS(ATOMIC_TICKS),
    .SPLIT_TICKS(SPLIT_TICKS),
    .CNT_W(16)
  ) u_nvm (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .osc_tick(osc_tick),
    .nvm(nvm)
  );

  // ========================================================================
  // checks
  arm_expiry_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(arm_q) |-> arm_q [*4] ##1 !arm_q)
    else $error("arm did not clear after four cycles");

  read_stall_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    take && go_rd_d |=> !wb_ack_o [*4] ##1 wb_ack_o)
    else $error("read stall not four cycles");

  prog_stall_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    take && go_pr_d |=> !wb_ack_o [*2] ##1 wb_ack_o)
    else $error("program stall not two cycles");

  busy_after_start_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    nvm.op_start |=> busy)
    else $error("busy not set after start");

  mode_lock_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    busy && fire |=> mode_q == $past(mode_q))
    else $error("mode changed while busy");

  refuse_busy_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    take && busy |=> !go_rd_q && !go_pr_q)
    else $error("access started while busy");

  start_armed_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    nvm.op_start |-> $past(arm_q, 3) && mode_q != EAC_MODE_RSVD)
    else $error("program started without arm");

  read_load_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    fire && go_rd_q |=> data_q == $past(nvm.rd_data))
    else $error("read byte not loaded");

  irq_gate_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(nvm_ready_irq) |-> ien_q && global_irq_en && !busy)
    else $error("ready irq without enable");

endmodule : eac_top

// ### dv/eac_cpu_model.sv
// wishbone classic master standing in for the cpu core.
// assumes a slave that answers a held request; the bench watchdog ends a hang.
`timescale 1ns/1ns
module eac_cpu_model (
  input wire logic clk_sys,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [3:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i
);
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 4'h0;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end

  // ==========================================================================
  // one classic cycle; lat counts edges from take to ack
  task automatic xfer(input logic we, input logic [3:0] adr,
                      input logic [31:0] dat, output logic [31:0] rdat,
                      output int lat);
    @(posedge clk_sys);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'h1;
    wb_dat_o <= dat;
    lat = -1;
    do begin
      @(posedge clk_sys);
      lat++;
    end while (wb_ack_i !== 1'b1);
    rdat = wb_dat_i;
    // released lines show no stale value
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_adr_o <= ~adr;
    wb_dat_o <= ~dat;
  endtask : xfer
endmodule : eac_cpu_model

// ### dv/testbench.sv
// self-checking bench of the byte eeprom access controller.
// assumes eac_top with shortened programming tick counts.
`timescale 1ns/1ns
`include "eac_defs.svh"
module testbench;
  localparam int AT = 20;
  localparam int ST = 10;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic osc_tick = 1'b0;
  logic gie = 1'b0;
  logic [1:0] div = 2'd0;
  logic cyc, stb, we, ack, irq;
  logic [3:0] adr, sel;
  logic [31:0] dw, dr, seed = 32'hc670;
  logic [31:0] exp_q[$];
  logic [7:0] a, d, d2;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc_n;
  time t_op;

  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    div <= (div == 2'd2) ? 2'd0 : div + 2'd1;
    osc_tick <= (div == 2'd2);
  end

  eac_top #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .osc_tick(osc_tick),
    .global_irq_en(gie), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .nvm_ready_irq(irq));
  eac_cpu_model u_cpu (
    .clk_sys(clk_sys), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dw), .wb_dat_i(dr),
    .wb_ack_i(ack));

  // ==========================================================================
  // helpers
  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] ad, input logic [7:0] v, input int el);
    logic [31:0] r;
    int l;
    u_cpu.xfer(1'b1, ad, {24'h0, v}, r, l);
    chk("ack_latency", el, l);
  endtask : wr

  task automatic rd(input logic [3:0] ad, input logic [7:0] e);
    logic [31:0] r;
    int l;
    exp_q.push_back({24'h0, e});
    u_cpu.xfer(1'b0, ad, 32'h0, r, l);
    chk("ack_latency", 1, l);
  endtask : rd

  // poll busy until clear; returns cycles since the last trigger ack
  task automatic wait_idle(output int n);
    logic [31:0] r;
    int l;
    for (int i = 0; i < 200; i++) begin
      u_cpu.xfer(1'b0, `EAC_ADR_CTRL, 32'h0, r, l);
      if (r[`EAC_CTRL_PB] === 1'b0) break;
    end
    n = int'(($time - t_op) / 40);
  endtask : wait_idle

  // address, data, mode, arm, gap, then trigger; ien kept set
  task automatic prog(input logic [1:0] m, input logic [7:0] ad,
                      input logic [7:0] v, input int gap, input int el);
    wr(`EAC_ADR_ADDR, ad, 1);
    wr(`EAC_ADR_DATA, v, 1);
    wr(`EAC_ADR_CTRL, {2'b00, m, 4'h8}, 1);
    wr(`EAC_ADR_CTRL, {2'b00, m, 4'hc}, 1);
    repeat (gap) @(posedge clk_sys);
    wr(`EAC_ADR_CTRL, {2'b00, m, 4'ha}, el);
    t_op = $time;
  endtask : prog

  task automatic rdb(input logic [7:0] ad, input logic [7:0] e);
    wr(`EAC_ADR_ADDR, ad, 1);
    wr(`EAC_ADR_CTRL, 8'h09, 5);
    rd(`EAC_ADR_DATA, e);
  endtask : rdb

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // ==========================================================================
  // result watcher: oldest note against each read answer
  always @(negedge clk_sys) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      chk("wb_dat_o", exp_q.pop_front(), dr);
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    finish_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    gie <= 1'b1;
    rd(`EAC_ADR_CTRL, 8'h00);
    rd(`EAC_ADR_ADDR, 8'h00);
    rd(`EAC_ADR_DATA, 8'h00);
    wr(4'hc, 8'hff, 1);
    rd(4'hc, 8'h00);
    seed = nxt(seed);
    a = seed[7:0];
    seed = nxt(seed);
    d = seed[15:8];
    prog(2'h0, a, d, 0, 3);
    rd(`EAC_ADR_CTRL, 8'h0a);
    chk("nvm_ready_irq", 0, irq);
    wr(`EAC_ADR_CTRL, 8'h18, 1);
    rd(`EAC_ADR_CTRL, 8'h0a);
    wr(`EAC_ADR_CTRL, 8'h09, 1);
    rd(`EAC_ADR_DATA, d);
    wait_idle(cyc_n);
    chk("atomic_len", 1, cyc_n >= 3*AT-4 && cyc_n <= 3*AT+7);
    chk("nvm_ready_irq", 1, irq);
    rdb(a, d);
    prog(2'h1, 8'hff, d, 0, 3);
    wait_idle(cyc_n);
    chk("erase_len", 1, cyc_n >= 3*ST-4 && cyc_n <= 3*ST+7);
    rdb(8'hff, 8'hff);
    seed = nxt(seed);
    d2 = seed[7:0];
    prog(2'h2, 8'hff, d2, 0, 3);
    wait_idle(cyc_n);
    chk("write_len", 1, cyc_n >= 3*ST-4 && cyc_n <= 3*ST+7);
    rdb(8'hff, d2);
    prog(2'h2, 8'hff, d, 0, 3);
    wait_idle(cyc_n);
    chk("write_len", 1, cyc_n >= 3*ST-4 && cyc_n <= 3*ST+7);
    rdb(8'hff, d2 & d);
    prog(2'h0, 8'hff, d, 0, 3);
    wait_idle(cyc_n);
    chk("atomic_len", 1, cyc_n >= 3*AT-4 && cyc_n <= 3*AT+7);
    rdb(8'hff, d);
    prog(2'h0, 8'h00, d, 4, 1);
    rd(`EAC_ADR_CTRL, 8'h08);
    prog(2'h3, 8'h00, d, 0, 1);
    rd(`EAC_ADR_CTRL, 8'h38);
    wr(`EAC_ADR_CTRL, 8'h0a, 1);
    rd(`EAC_ADR_CTRL, 8'h08);
    wr(`EAC_ADR_CTRL, 8'h00, 1);
    @(negedge clk_sys);
    chk("nvm_ready_irq", 0, irq);
    wr(`EAC_ADR_CTRL, 8'h08, 1);
    gie <= 1'b0;
    @(posedge clk_sys);
    #1 chk("nvm_ready_irq", 0, irq);
    @(posedge clk_sys);
    gie <= 1'b1;
    @(posedge clk_sys);
    #1 chk("nvm_ready_irq", 1, irq);
    repeat (4) @(posedge clk_sys);
    chk("queue_empty", 0, exp_q.size());
    finish_test();
  end
endmodule : testbench
